// [rtl/cvs_pkg.sv]
// Shared constants and types for the charger voltage setting registers
package cvs_pkg;

  // Register indices as printed; byte address is four times the index
  localparam logic [7:0] BATT_IDX  = 8'h05;
  localparam logic [7:0] SYS_IDX   = 8'h06;
  localparam logic [7:0] BATT_ADDR = 8'(BATT_IDX * 8'h04);
  localparam logic [7:0] SYS_ADDR  = 8'(SYS_IDX * 8'h04);

  localparam logic [7:0] BATT_RESET = 8'h78;
  localparam logic [7:0] SYS_RESET  = 8'h82;

  // Field positions
  localparam int unsigned CODE_LSB = 1;
  localparam int unsigned CODE_MSB = 7;

  // Battery regulation, millivolts (3600, 10, 4650)
  localparam logic [12:0] BATT_BASE_MV = 13'h0e10;
  localparam logic [12:0] BATT_STEP_MV = 13'h000a;
  localparam logic [12:0] BATT_MAX_MV  = 13'h122a;
  localparam logic [6:0]  BATT_MAX_CODE =
    7'((BATT_MAX_MV - BATT_BASE_MV) / BATT_STEP_MV);

  // System output, millivolts (1100, 1200, 1300, 1800)
  localparam logic [11:0] SEL00_C0_MV = 12'h044c;
  localparam logic [11:0] SEL00_C1_MV = 12'h04b0;
  localparam logic [11:0] SEL01_BASE_MV = 12'h0514;
  localparam logic [11:0] SEL11_BASE_MV = 12'h0708;
  localparam logic [11:0] SYS_RESET_MV  = SEL00_C1_MV;
  // Bit weights of the code in the linear ranges (800, 400, 200, 100)
  localparam logic [11:0] W3_MV = 12'h0320;
  localparam logic [11:0] W2_MV = 12'h0190;
  localparam logic [11:0] W1_MV = 12'h00c8;
  localparam logic [11:0] W0_MV = 12'h0064;
  // Table ranges step in twelfths of a volt, except range 00 codes 0 and 1
  localparam logic [5:0]  SEL00_TW_OFS = 6'h0d;
  localparam logic [5:0]  SEL10_TW_OFS = 6'h12;
  localparam logic [15:0] TW_SCALE     = 16'h03e8;
  localparam logic [15:0] TW_ROUND     = 16'h0006;
  localparam logic [15:0] TW_DIV       = 16'h000c;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    RANGE_TBL_LOW = 2'b00,
    RANGE_LIN_LOW = 2'b01,
    RANGE_TBL_HI  = 2'b10,
    RANGE_LIN_HI  = 2'b11
  } cvs_range_t;

  typedef struct packed {
    logic       sys_out_enable;
    cvs_range_t out_range_select;
    logic [3:0] out_voltage_code;
  } cvs_sys_ctrl_t;

  localparam cvs_sys_ctrl_t SYS_RESET_CTRL =
    cvs_sys_ctrl_t'(SYS_RESET[CODE_MSB:CODE_LSB]);

  typedef struct packed {
    logic [6:0]    batt_reg_code;
    logic [12:0]   batt_reg_voltage;
    cvs_sys_ctrl_t sys;
    logic [11:0]   out_voltage_mv;
    logic          switch_node_pulldown;
  } cvs_reg_out_t;

  function automatic logic [12:0] batt_code_to_mv(input logic [6:0] code);
    batt_code_to_mv = 13'(BATT_BASE_MV + 13'(code) * BATT_STEP_MV);
  endfunction : batt_code_to_mv

endpackage : cvs_pkg

// [rtl/cvs_batt_limit.sv]
// Battery regulation code limiter and voltage conversion
`timescale 1ns/1ps
module cvs_batt_limit (
  input  wire logic [6:0]  raw_code,
  output logic      [6:0]  lim_code,
  output logic      [12:0] lim_mv
);

  always_comb begin
    lim_code = (raw_code > cvs_pkg::BATT_MAX_CODE) ? cvs_pkg::BATT_MAX_CODE : raw_code;
    lim_mv   = cvs_pkg::batt_code_to_mv(lim_code);
  end

endmodule : cvs_batt_limit

// [rtl/cvs_sys_decode.sv]
// System output range and code to millivolt decoder
`timescale 1ns/1ps
module cvs_sys_decode (
  input  wire cvs_pkg::cvs_sys_ctrl_t ctrl,
  output logic [11:0]                 out_mv
);

  // Table ranges are whole twelfths of a volt, rounded to the millivolt, except range 00 codes 0 and 1
  function automatic logic [11:0] twelfths_mv(input logic [5:0] n);
    logic [15:0] num;
    num = 16'(16'(n) * cvs_pkg::TW_SCALE + cvs_pkg::TW_ROUND);
    twelfths_mv = 12'(num / cvs_pkg::TW_DIV);
  endfunction : twelfths_mv

  function automatic logic [11:0] linear_mv(input logic [11:0] base,
                                            input logic [3:0]  code);
    linear_mv = 12'(base + (code[3] ? cvs_pkg::W3_MV : 12'h0000)
                         + (code[2] ? cvs_pkg::W2_MV : 12'h0000)
                         + (code[1] ? cvs_pkg::W1_MV : 12'h0000)
                         + (code[0] ? cvs_pkg::W0_MV : 12'h0000));
  endfunction : linear_mv

  logic [3:0] code;
  assign code = ctrl.out_voltage_code;

  always_comb begin
    unique case (ctrl.out_range_select)
      cvs_pkg::RANGE_TBL_LOW: begin
        if (code == 4'h0)
          out_mv = cvs_pkg::SEL00_C0_MV;
        else if (code == 4'h1)
          out_mv = cvs_pkg::SEL00_C1_MV;
        else
          out_mv = twelfths_mv(6'(code) + cvs_pkg::SEL00_TW_OFS);
      end
      cvs_pkg::RANGE_LIN_LOW: out_mv = linear_mv(cvs_pkg::SEL01_BASE_MV, code);
      cvs_pkg::RANGE_TBL_HI:  out_mv = twelfths_mv(6'(code) + cvs_pkg::SEL10_TW_OFS);
      cvs_pkg::RANGE_LIN_HI:  out_mv = linear_mv(cvs_pkg::SEL11_BASE_MV, code);
    endcase
  end

endmodule : cvs_sys_decode

// [rtl/cvs_regs.sv]
// Charger voltage setting registers behind an AXI4-Lite slave
`timescale 1ns/1ps
module cvs_regs (
  input  wire logic                mclk,
  input  wire logic                rst,
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  output cvs_pkg::cvs_reg_out_t    reg_out
);

  typedef struct packed {
    logic                   aw_full;
    logic [7:0]             aw_addr;
    logic                   w_full;
    logic [7:0]             w_byte;
    logic                   w_lane;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   rvalid;
    logic [7:0]             rbyte;
    logic [1:0]             rresp;
    logic [6:0]             batt_code;
    logic [12:0]            batt_mv;
    cvs_pkg::cvs_sys_ctrl_t sys;
    logic [11:0]            sys_mv;
  } cvs_state_t;

  localparam cvs_state_t RST_STATE = '{
    batt_code: cvs_pkg::BATT_RESET[cvs_pkg::CODE_MSB:cvs_pkg::CODE_LSB],
    batt_mv:   cvs_pkg::batt_code_to_mv(
                 cvs_pkg::BATT_RESET[cvs_pkg::CODE_MSB:cvs_pkg::CODE_LSB]),
    sys:       cvs_pkg::SYS_RESET_CTRL,
    sys_mv:    cvs_pkg::SYS_RESET_MV,
    default:   '0
  };

  cvs_state_t q;
  cvs_state_t d;

  logic       aw_hs;
  logic       w_hs;
  logic       ar_hs;
  logic       wr_go;
  logic       wr_batt;
  logic       wr_sys;
  logic [6:0] lim_code;
  logic [12:0] lim_mv;
  logic [11:0] dec_mv;
  cvs_pkg::cvs_sys_ctrl_t w_sys;

  function automatic logic hits(input logic [7:0] addr,
                                input logic [7:0] reg_addr);
    hits = (addr == reg_addr);
  endfunction : hits

  function automatic logic mapped(input logic [7:0] addr);
    mapped = hits(addr, cvs_pkg::BATT_ADDR) || hits(addr, cvs_pkg::SYS_ADDR);
  endfunction : mapped

  // Incoming byte with bit 0 dropped; it is never stored
  assign w_sys = cvs_pkg::cvs_sys_ctrl_t'(q.w_byte[cvs_pkg::CODE_MSB:cvs_pkg::CODE_LSB]);

  // Limiter and decoder look at the pending write byte, so the stored
  // code and its millivolt value change on the same edge
  cvs_batt_limit u_batt_limit (
    .raw_code (q.w_byte[cvs_pkg::CODE_MSB:cvs_pkg::CODE_LSB]),
    .lim_code (lim_code),
    .lim_mv   (lim_mv)
  );

  cvs_sys_decode u_sys_decode (
    .ctrl   (w_sys),
    .out_mv (dec_mv)
  );

  // Address and data are held apart until both have arrived
  assign s_axi_awready = !q.aw_full;
  assign s_axi_wready  = !q.w_full;
  // One read in flight; a stalled rready blocks the next address
  assign s_axi_arready = !q.rvalid;

  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs  = s_axi_wvalid && s_axi_wready;
  assign ar_hs = s_axi_arvalid && s_axi_arready;

  assign wr_go   = q.aw_full && q.w_full && !q.bvalid;
  assign wr_batt = wr_go && q.w_lane && hits(q.aw_addr, cvs_pkg::BATT_ADDR);
  assign wr_sys  = wr_go && q.w_lane && hits(q.aw_addr, cvs_pkg::SYS_ADDR);

  always_comb begin
    d = q;

    if (aw_hs) begin
      d.aw_full = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    if (w_hs) begin
      d.w_full = 1'b1;
      d.w_byte = s_axi_wdata[7:0];
      d.w_lane = s_axi_wstrb[0];
    end

    if (q.bvalid && s_axi_bready)
      d.bvalid = 1'b0;

    if (wr_go) begin
      d.aw_full = 1'b0;
      d.w_full  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = mapped(q.aw_addr) ? cvs_pkg::RESP_OKAY : cvs_pkg::RESP_SLVERR;
    end

    if (wr_batt) begin
      d.batt_code = lim_code;
      d.batt_mv   = lim_mv;
    end

    if (wr_sys) begin
      d.sys    = w_sys;
      d.sys_mv = dec_mv;
    end

    if (q.rvalid && s_axi_rready)
      d.rvalid = 1'b0;

    if (ar_hs) begin
      d.rvalid = 1'b1;
      d.rresp  = cvs_pkg::RESP_OKAY;
      if (hits(s_axi_araddr, cvs_pkg::BATT_ADDR))
        d.rbyte = {q.batt_code, 1'b0};
      else if (hits(s_axi_araddr, cvs_pkg::SYS_ADDR))
        d.rbyte = {q.sys, 1'b0};
      else begin
        d.rbyte = 8'h00;
        d.rresp = cvs_pkg::RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst)
      q <= RST_STATE;
    else
      q <= d;
  end

  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp  = q.bresp;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rresp  = q.rresp;
  assign s_axi_rdata  = {24'h00_0000, q.rbyte};

  always_comb begin
    reg_out.batt_reg_code    = q.batt_code;
    reg_out.batt_reg_voltage = q.batt_mv;
    reg_out.sys              = q.sys;
    reg_out.out_voltage_mv   = q.sys_mv;
    reg_out.switch_node_pulldown = !q.sys.sys_out_enable;
  end

  // Checks

  logic [6:0] raw_w;
  assign raw_w = q.w_byte[cvs_pkg::CODE_MSB:cvs_pkg::CODE_LSB];

  logic [3:0] vc;
  assign vc = q.sys.out_voltage_code;

  sequence s_batt_write_ok;
    wr_batt && (raw_w <= cvs_pkg::BATT_MAX_CODE);
  endsequence

  sequence s_batt_write_big;
    wr_batt && (raw_w > cvs_pkg::BATT_MAX_CODE);
  endsequence

  sequence s_both_taken;
    q.aw_full && q.w_full && !q.bvalid;
  endsequence

  property p_batt_field;
    @(posedge mclk) disable iff (rst)
    s_batt_write_ok |=> (q.batt_code == $past(raw_w)) && s_axi_bvalid;
  endproperty
  a_batt_field: assert property (p_batt_field)
    else $error("battery code not stored as written");

  property p_batt_limit;
    @(posedge mclk) disable iff (rst)
    s_batt_write_big |=> (q.batt_code == 7'h69) && (q.batt_mv == 13'h122a);
  endproperty
  a_batt_limit: assert property (p_batt_limit)
    else $error("battery code above ceiling not limited");

  property p_batt_mv;
    @(posedge mclk) disable iff (rst)
    1'b1 |-> q.batt_mv == 13'(13'h0e10 + 13'(q.batt_code) * 13'h000a);
  endproperty
  a_batt_mv: assert property (p_batt_mv)
    else $error("battery voltage does not match code");

  property p_enable;
    @(posedge mclk) disable iff (rst)
    $changed(q.sys.sys_out_enable) |->
      (reg_out.switch_node_pulldown != q.sys.sys_out_enable) && $past(wr_sys);
  endproperty
  a_enable: assert property (p_enable)
    else $error("enable changed without a write or pulldown wrong");

  property p_sel00;
    @(posedge mclk) disable iff (rst)
    (q.sys.out_range_select == cvs_pkg::RANGE_TBL_LOW) |->
      (vc == 4'h0) ? (q.sys_mv == 12'h044c) :
      (vc == 4'h1) ? (q.sys_mv == 12'h04b0) :
      (vc == 4'hf) ? (q.sys_mv == 12'h091d) :
      (q.sys_mv > 12'h04b0 && q.sys_mv < 12'h091d);
  endproperty
  a_sel00: assert property (p_sel00)
    else $error("range 00 voltage wrong");

  property p_sel01;
    @(posedge mclk) disable iff (rst)
    (q.sys.out_range_select == cvs_pkg::RANGE_LIN_LOW) |->
      q.sys_mv == 12'(12'h0514 + 12'(vc) * 12'h0064);
  endproperty
  a_sel01: assert property (p_sel01)
    else $error("range 01 voltage wrong");

  property p_sel10;
    @(posedge mclk) disable iff (rst)
    (q.sys.out_range_select == cvs_pkg::RANGE_TBL_HI) |->
      (vc == 4'h0) ? (q.sys_mv == 12'h05dc) :
      (vc == 4'hf) ? (q.sys_mv == 12'h0abe) :
      (vc == 4'h6) ? (q.sys_mv == 12'h07d0) :
      (q.sys_mv > 12'h05dc && q.sys_mv < 12'h0abe);
  endproperty
  a_sel10: assert property (p_sel10)
    else $error("range 10 voltage wrong");

  property p_sel11;
    @(posedge mclk) disable iff (rst)
    (q.sys.out_range_select == cvs_pkg::RANGE_LIN_HI) |->
      q.sys_mv == 12'(12'h0708 + 12'(vc) * 12'h0064);
  endproperty
  a_sel11: assert property (p_sel11)
    else $error("range 11 voltage wrong");

  property p_weights;
    @(posedge mclk) disable iff (rst)
    (q.sys.out_range_select[0] && vc[3]) |->
      q.sys_mv - (q.sys.out_range_select[1] ? 12'h0708 : 12'h0514) >= 12'h0320;
  endproperty
  a_weights: assert property (p_weights)
    else $error("code bit 3 weight missing");

  property p_reset_val;
    @(posedge mclk)
    $past(rst) |-> ({q.sys, 1'b0} == 8'h82) && (q.sys_mv == 12'h04b0)
                   && !reg_out.switch_node_pulldown;
  endproperty
  a_reset_val: assert property (p_reset_val)
    else $error("system output register reset value wrong");

  property p_bit0;
    @(posedge mclk) disable iff (rst)
    s_axi_rvalid |-> (s_axi_rdata[0] == 1'b0) && (s_axi_rdata[31:8] == 24'h00_0000);
  endproperty
  a_bit0: assert property (p_bit0)
    else $error("bit 0 or upper bits read nonzero");

  property p_write_resp;
    @(posedge mclk) disable iff (rst)
    s_both_taken |=> s_axi_bvalid && !q.aw_full && !q.w_full;
  endproperty
  a_write_resp: assert property (p_write_resp)
    else $error("write response not raised one cycle after both parts");

  property p_resp_hold;
    @(posedge mclk) disable iff (rst)
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_resp_hold: assert property (p_resp_hold)
    else $error("write response dropped before bready");

  property p_read_resp;
    @(posedge mclk) disable iff (rst)
    ar_hs |=> s_axi_rvalid
      && (s_axi_rresp == (mapped($past(s_axi_araddr)) ? 2'h0 : 2'h2));
  endproperty
  a_read_resp: assert property (p_read_resp)
    else $error("read answer late or wrong response");

  property p_batt_ceiling;
    @(posedge mclk) disable iff (rst)
    1'b1 |-> q.batt_code <= 7'h69;
  endproperty
  a_batt_ceiling: assert property (p_batt_ceiling)
    else $error("stored battery code above ceiling");

  // Only the seven upper bits land; bit 0 of the write is dropped
  property p_sys_field;
    @(posedge mclk) disable iff (rst)
    wr_sys |=> (q.sys == $past(raw_w)) && (s_axi_bresp == 2'h0);
  endproperty
  a_sys_field: assert property (p_sys_field)
    else $error("system output fields not stored as written");

  // Strobe low or unmapped address must leave both registers alone
  property p_write_ignored;
    @(posedge mclk) disable iff (rst)
    (wr_go && !(wr_batt || wr_sys)) |=> $stable(q.batt_code) && $stable(q.sys)
      && $stable(q.batt_mv) && $stable(q.sys_mv);
  endproperty
  a_write_ignored: assert property (p_write_ignored)
    else $error("ignored write changed a register");

  // Read data is the register image at the edge the address was taken
  property p_read_sys;
    @(posedge mclk) disable iff (rst)
    (ar_hs && hits(s_axi_araddr, cvs_pkg::SYS_ADDR)) |=>
      (s_axi_rdata[7:1] == $past(q.sys)) && s_axi_rvalid;
  endproperty
  a_read_sys: assert property (p_read_sys)
    else $error("system output read data wrong");

endmodule : cvs_regs

// [bench/cvs_regs_tb.sv]
// Self-checking testbench for the charger voltage setting registers
`timescale 1ns/1ps
`define CHK(got, exp, msg) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
      errors++; \
      $display("CHECK FAILED t=%0t %s", $time, msg); \
    end \
  end
module cvs_regs_tb;
  logic                  mclk;
  logic                  rst;
  logic [7:0]            awaddr;
  logic                  awvalid;
  logic                  awready;
  logic [31:0]           wdata;
  logic [3:0]            wstrb;
  logic                  wvalid;
  logic                  wready;
  logic [1:0]            bresp;
  logic                  bvalid;
  logic                  bready;
  logic [7:0]            araddr;
  logic                  arvalid;
  logic                  arready;
  logic [31:0]           rdata;
  logic [1:0]            rresp;
  logic                  rvalid;
  logic                  rready;
  cvs_pkg::cvs_reg_out_t ro;
  int                    errors;
  int                    cmp_count;
  logic [31:0]           rd;
  logic [1:0]            resp;

  cvs_regs dut_u (
    .mclk(mclk), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .reg_out(ro)
  );

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish

  // Handshakes are judged on settled values at the falling edge, acted on at the rising one
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] r);
    logic hit_aw;
    logic hit_w;
    logic hit_b;
    int   n;
    @(posedge mclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    n = 0;
    do begin
      @(negedge mclk);
      hit_aw = awvalid && awready;
      hit_w  = wvalid && wready;
      hit_b  = bvalid && bready;
      r      = bresp;
      @(posedge mclk);
      if (hit_aw) awvalid <= 1'b0;
      if (hit_w) wvalid <= 1'b0;
      n++;
    end while (!hit_b && n < 50);
    bready <= 1'b0;
    if (!hit_b) begin
      errors++;
      $display("CHECK FAILED t=%0t write response missing", $time);
    end
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic hit_ar;
    logic hit_r;
    int   n;
    @(posedge mclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    n = 0;
    do begin
      @(negedge mclk);
      hit_ar = arvalid && arready;
      hit_r  = rvalid && rready;
      d      = rdata;
      r      = rresp;
      @(posedge mclk);
      if (hit_ar) arvalid <= 1'b0;
      n++;
    end while (!hit_r && n < 50);
    rready <= 1'b0;
    if (!hit_r) begin
      errors++;
      $display("CHECK FAILED t=%0t read response missing", $time);
    end
  endtask : axi_read

  task automatic apply_reset();
    @(posedge mclk);
    rst <= 1'b1;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
  endtask : apply_reset

  task automatic check_defaults(input string name);
    axi_read(cvs_pkg::SYS_ADDR, rd, resp);
    `CHK(rd, 32'h0000_0082, "system output reset value")
    `CHK(resp, cvs_pkg::RESP_OKAY, "system output read response")
    axi_read(cvs_pkg::BATT_ADDR, rd, resp);
    `CHK(rd, 32'h0000_0078, "battery reset value")
    `CHK(ro.batt_reg_voltage, 13'h1068, "battery reset voltage")
    `CHK(ro.sys.sys_out_enable, 1'b1, "enable after reset")
    `CHK(ro.sys.out_range_select, 2'b00, "range after reset")
    `CHK(ro.sys.out_voltage_code, 4'h1, "code after reset")
    `CHK(ro.out_voltage_mv, 12'h04b0, "voltage after reset")
    `CHK(ro.switch_node_pulldown, 1'b0, "pulldown after reset")
    $display("test %s done", name);
  endtask : check_defaults

  // Voltage table built from the documented codes, in millivolts
  function automatic int sys_mv(input int sel, input int code);
    case (sel)
      0: sys_mv = (code == 0) ? 1100 : (code == 1) ? 1200 : ((code + 13) * 1000 + 6) / 12;
      1: sys_mv = 1300 + 100 * code;
      2: sys_mv = ((code + 18) * 1000 + 6) / 12;
      default: sys_mv = 1800 + 100 * code;
    endcase
  endfunction : sys_mv

  initial begin
    int   lim;
    logic en;
    errors = 0;
    cmp_count = 0;
    rst = 1'b1;
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h0000_0000;
    wstrb = 4'h0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    check_defaults("reset_values");

    // Every battery code, bit 0 written high to show it is dropped
    for (int c = 0; c < 128; c++) begin
      lim = (c > 105) ? 105 : c;
      axi_write(cvs_pkg::BATT_ADDR, 32'(c * 2 + 1), 4'h1, resp);
      `CHK(resp, cvs_pkg::RESP_OKAY, "battery write response")
      `CHK(ro.batt_reg_code, 7'(lim), "battery code limited")
      `CHK(ro.batt_reg_voltage, 13'(3600 + 10 * lim), "battery voltage")
      axi_read(cvs_pkg::BATT_ADDR, rd, resp);
      `CHK(rd, 32'(lim * 2), "battery readback")
    end
    $display("test battery_codes done");

    // Every range and code, enable toggling so both converter states are seen
    for (int s = 0; s < 4; s++) begin
      for (int c = 0; c < 16; c++) begin
        en = 1'(c % 2) ^ 1'(s / 2);
        axi_write(cvs_pkg::SYS_ADDR, 32'({en, 2'(s), 4'(c), 1'b1}), 4'h1, resp);
        `CHK(ro.sys.sys_out_enable, en, "enable bit")
        `CHK(ro.switch_node_pulldown, !en, "pulldown follows enable")
        `CHK(ro.sys.out_range_select, 2'(s), "range field")
        `CHK(ro.sys.out_voltage_code, 4'(c), "code field")
        case (s)
          0: `CHK(ro.out_voltage_mv, 12'(sys_mv(s, c)), "range 00 voltage")
          1: `CHK(ro.out_voltage_mv, 12'(sys_mv(s, c)), "range 01 voltage")
          2: `CHK(ro.out_voltage_mv, 12'(sys_mv(s, c)), "range 10 voltage")
          default: `CHK(ro.out_voltage_mv, 12'(sys_mv(s, c)), "range 11 voltage")
        endcase
        axi_read(cvs_pkg::SYS_ADDR, rd, resp);
        `CHK(rd, 32'({en, 2'(s), 4'(c), 1'b0}), "system readback")
      end
    end
    $display("test system_codes done");

    // Strobe low and unmapped places must leave the registers alone
    axi_write(cvs_pkg::SYS_ADDR, 32'h0000_00ff, 4'h0, resp);
    `CHK(resp, cvs_pkg::RESP_OKAY, "strobe low response")
    axi_write(8'h1c, 32'h0000_0000, 4'hf, resp);
    `CHK(resp, cvs_pkg::RESP_SLVERR, "unmapped write response")
    axi_read(8'h00, rd, resp);
    `CHK(resp, cvs_pkg::RESP_SLVERR, "unmapped read response")
    `CHK(rd, 32'h0000_0000, "unmapped read data")
    axi_read(cvs_pkg::SYS_ADDR, rd, resp);
    `CHK(rd, 32'h0000_007e, "system unchanged")
    $display("test refused_writes done");

    axi_write(cvs_pkg::BATT_ADDR, 32'h0000_0010, 4'h1, resp);
    `CHK(ro.batt_reg_code, 7'h08, "battery code before second reset")
    apply_reset();
    check_defaults("second_reset");
    tally_and_finish();
  end

  // Full run is about fourteen hundred cycles; this leaves a wide margin
  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    $display("CHECK FAILED t=%0t run did not finish", $time);
    tally_and_finish();
  end
endmodule : cvs_regs_tb
